// ==== dag_core.sv ====
// operand address generator: program counter, pointer windows, indexed literal offset
// Summary of operation
// - program counter is 21 bits wide
// - fetch above implemented memory returns zero
// - reset starts at zero; vectors 0008h, 0018h
// - implemented program memory 16 or 32 Kbytes
// - fetch and data access on separate buses
// - plus-accumulator window adds accumulator to pointer
// - indirect read of a window returns 00h
// - indirect write of a window stores nothing; a post-decrement window still decrements its pointer
// - window write into pointer skips post-decrement
// - pointers are physical, directly readable and writable
// - indirect access to other registers works normally
// - extended addressing only when select bit set
// - first two pointers unchanged by extension
// - inherent and literal instructions unaffected
// - indexed mode needs access 0, address <= 5Fh
// - indexed target is third pointer plus offset
// - access 1 or address >= 60h stays direct
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module dag_core #(
  parameter int PM_BYTES = dag_pkg::PM_BYTES_DEF
) (
  input  wire logic                       clock,
  input  wire logic                       rst_b,
  input  wire logic [dag_pkg::AXI_AW-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [dag_pkg::AXI_AW-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  input  wire logic                       op_valid,
  output logic                            op_ready,
  input  wire logic [7:0]                 op_faddr,
  input  wire logic                       op_access,
  input  wire logic                       op_write,
  input  wire logic [7:0]                 op_wdata,
  output logic [7:0]                      op_rdata,
  output logic                            op_done,
  output logic [dag_pkg::DA_W-1:0]        mem_addr,
  output logic                            mem_re,
  output logic                            mem_we,
  output logic [7:0]                      mem_wdata,
  input  wire logic [7:0]                 mem_rdata,
  input  wire dag_pkg::dag_pc_cmd_t       pc_cmd,
  input  wire logic [dag_pkg::PC_W-1:0]   pc_load_addr,
  output logic [dag_pkg::PC_W-1:0]        pm_addr,
  input  wire logic [15:0]                pm_rdata,
  output logic [15:0]                     fetch_word
);
  import dag_pkg::*;

  localparam logic [PC_W:0] PM_TOP = (PC_W+1)'(PM_BYTES);

  // architectural state
  logic [11:0] ptr_r [3];
  logic [11:0] ptr_nxt [3];
  logic [7:0]  acc_r, acc_nxt;
  logic [3:0]  bank_r, bank_nxt;
  logic        extended_isa_select_r, extended_isa_select_nxt;
  logic [20:0] pc_r, pc_nxt;

  // operand stage one
  logic        s1_valid_r, s1_valid_nxt;
  logic [11:0] s1_addr_r, s1_addr_nxt;
  logic        s1_write_r, s1_write_nxt;
  logic [7:0]  s1_data_r, s1_data_nxt;
  logic        s1_null_r, s1_null_nxt;
  logic        s1_int_r, s1_int_nxt;
  logic        s1_dec_r, s1_dec_nxt;
  logic [1:0]  s1_didx_r, s1_didx_nxt;
  logic [7:0]  rd_r, rd_nxt;
  logic        done_r, done_nxt;

  // bus slave state
  logic        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [7:0]  aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0]  w_strb_r, w_strb_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // address resolution terms
  logic        take, idx_mode, axi_wr, is_int;
  logic [11:0] dir_addr, idx_sum, plus_sum, eff_addr, tgt_addr;
  logic [7:0]  int_rd;

  dag_win_if w_eff ();
  dag_win_if w_tgt ();
  dag_win_decode u_dec_eff (.w(w_eff));
  dag_win_decode u_dec_tgt (.w(w_tgt));

  // a second op waits one cycle so its pointer reads see the previous write
  assign op_ready = ~s1_valid_r;
  assign take     = op_valid & op_ready;

  // only file operations come through here, so other instructions never see the mode bit
  assign idx_mode = extended_isa_select_r & ~op_access & (op_faddr <= FA_INDEX_MAX);
  assign idx_sum  = ptr_r[THIRD_PTR] + {4'h0, op_faddr};
  assign plus_sum = ptr_r[w_eff.idx] + {{4{acc_r[7]}}, acc_r};

  // direct form: banked when access is 1, otherwise split access bank
  always_comb begin
    if (op_access) begin
      dir_addr = {bank_r, op_faddr};
    end else if (op_faddr < FA_ACC_SPLIT) begin
      dir_addr = {ACC_LO_BANK, op_faddr};
    end else begin
      dir_addr = {ACC_HI_BANK, op_faddr};
    end
  end

  // windows resolve through their pointer; the bank register plays no part in indexed mode
  always_comb begin
    eff_addr    = idx_mode ? idx_sum : dir_addr;
    w_eff.addr  = eff_addr;
    tgt_addr    = eff_addr;
    if (w_eff.hit) begin
      tgt_addr = (w_eff.kind == WIN_PLUSACC) ? plus_sum : ptr_r[w_eff.idx];
    end
    w_tgt.addr  = tgt_addr;
  end

  // internal registers answer on their own; every other address goes to memory space unless it is a window reached through a window
  always_comb begin
    is_int = w_tgt.ptr_reg | (tgt_addr == ACC_ADDR) | (tgt_addr == BANK_ADDR);
    int_rd = NULL_READ;
    for (int i = 0; i < 3; i++) begin
      if (tgt_addr == PTR_LO_ADDR[i]) begin
        int_rd = ptr_r[i][7:0];
      end
      if (tgt_addr == PTR_HI_ADDR[i]) begin
        int_rd = {4'h0, ptr_r[i][11:8]};
      end
    end
    if (tgt_addr == ACC_ADDR) begin
      int_rd = acc_r;
    end
    if (tgt_addr == BANK_ADDR) begin
      int_rd = {4'h0, bank_r};
    end
  end

  // stage one capture and read-data return
  always_comb begin
    s1_valid_nxt = take;
    s1_addr_nxt  = s1_addr_r;
    s1_write_nxt = s1_write_r;
    s1_data_nxt  = s1_data_r;
    s1_null_nxt  = s1_null_r;
    s1_int_nxt   = s1_int_r;
    s1_dec_nxt   = 1'b0;
    s1_didx_nxt  = s1_didx_r;
    done_nxt     = s1_valid_r;
    rd_nxt       = rd_r;
    if (take) begin
      s1_addr_nxt  = tgt_addr;
      s1_write_nxt = op_write;
      s1_data_nxt  = op_write ? op_wdata : int_rd;
      s1_null_nxt  = w_eff.hit & w_tgt.hit;
      s1_int_nxt   = is_int;
      s1_didx_nxt  = w_eff.idx;
      // storing into a pointer through a window leaves the pair as written
      s1_dec_nxt   = w_eff.hit & (w_eff.kind == WIN_POSTDEC) & ~(op_write & w_tgt.ptr_reg);
    end
    if (s1_valid_r && !s1_write_r) begin
      if (s1_null_r) begin
        rd_nxt = NULL_READ;
      end else if (s1_int_r) begin
        rd_nxt = s1_data_r;
      end else begin
        rd_nxt = mem_rdata;
      end
    end
  end

  // memory strobes come straight from stage one flops
  assign mem_addr  = s1_addr_r;
  assign mem_wdata = s1_data_r;
  assign mem_we    = s1_valid_r & s1_write_r & ~s1_null_r & ~s1_int_r;
  assign mem_re    = s1_valid_r & ~s1_write_r & ~s1_null_r & ~s1_int_r;
  assign op_rdata  = rd_r;
  assign op_done   = done_r;

  // bus write lands only while no core write is pending, so the two never collide
  assign axi_wr = aw_have_r & w_have_r & ~bvalid_r & ~s1_valid_r;

  // register file next state: core write-back first, then bus writes
  always_comb begin
    ptr_nxt   = ptr_r;
    acc_nxt   = acc_r;
    bank_nxt  = bank_r;
    extended_isa_select_nxt = extended_isa_select_r;
    if (s1_valid_r) begin
      if (s1_dec_r) begin
        ptr_nxt[s1_didx_r] = ptr_r[s1_didx_r] - 12'h001;
      end
      if (s1_write_r && s1_int_r) begin
        for (int i = 0; i < 3; i++) begin
          if (s1_addr_r == PTR_LO_ADDR[i]) begin
            ptr_nxt[i][7:0] = s1_data_r;
          end
          if (s1_addr_r == PTR_HI_ADDR[i]) begin
            ptr_nxt[i][11:8] = s1_data_r[3:0];
          end
        end
        if (s1_addr_r == ACC_ADDR) begin
          acc_nxt = s1_data_r;
        end
        if (s1_addr_r == BANK_ADDR) begin
          bank_nxt = s1_data_r[3:0];
        end
      end
    end else if (axi_wr) begin
      unique case (aw_addr_r)
        REG_CTRL: begin
          if (w_strb_r[0]) extended_isa_select_nxt = w_data_r[CTRL_EXTENDED_ISA_SELECT];
        end
        REG_PTR0, REG_PTR1, REG_PTR2: begin
          if (w_strb_r[0]) ptr_nxt[aw_addr_r[3:2] - 2'h1][7:0] = w_data_r[7:0];
          if (w_strb_r[1]) ptr_nxt[aw_addr_r[3:2] - 2'h1][11:8] = w_data_r[11:8];
        end
        REG_ACC: begin
          if (w_strb_r[0]) acc_nxt = w_data_r[7:0];
        end
        REG_BANK: begin
          if (w_strb_r[0]) bank_nxt = w_data_r[3:0];
        end
        default: ;
      endcase
    end
  end

  // bus slave: address and data taken in either order, response after both
  always_comb begin
    aw_have_nxt = aw_have_r;
    aw_addr_nxt = aw_addr_r;
    w_have_nxt  = w_have_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r & ~bready;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r & ~rready;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (awvalid && awready) begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = {awaddr[7:2], 2'b00};
    end
    if (wvalid && wready) begin
      w_have_nxt = 1'b1;
      w_data_nxt = wdata;
      w_strb_nxt = wstrb;
    end
    if (axi_wr) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = (aw_addr_r <= REG_BANK) ? RESP_OKAY : RESP_SLVERR;
    end
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      unique case ({araddr[7:2], 2'b00})
        REG_CTRL: rdata_nxt = {31'h0, extended_isa_select_r};
        REG_PTR0: rdata_nxt = {20'h0, ptr_r[0]};
        REG_PTR1: rdata_nxt = {20'h0, ptr_r[1]};
        REG_PTR2: rdata_nxt = {20'h0, ptr_r[2]};
        REG_ACC:  rdata_nxt = {24'h0, acc_r};
        REG_BANK: rdata_nxt = {28'h0, bank_r};
        REG_PC:   rdata_nxt = {11'h0, pc_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  assign awready = ~aw_have_r & ~bvalid_r;
  assign wready  = ~w_have_r & ~bvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = ~rvalid_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  // program counter; word steps, vectors are fixed addresses
  always_comb begin
    unique case (pc_cmd)
      PC_INC:    pc_nxt = pc_r + PC_STEP;
      PC_LOAD:   pc_nxt = {pc_load_addr[20:1], 1'b0};
      PC_VEC_HI: pc_nxt = VEC_HIGH;
      PC_VEC_LO: pc_nxt = VEC_LOW;
      default:   pc_nxt = pc_r;
    endcase
  end

  // fetch runs on its own bus beside the data port
  assign pm_addr    = pc_r;
  assign fetch_word = ({1'b0, pc_r} < PM_TOP) ? pm_rdata : FETCH_NOP;

  // all state registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 3; i++) ptr_r[i] <= PTR_RST;
      acc_r      <= ACC_RST;
      bank_r     <= BANK_RST;
      extended_isa_select_r    <= EXTENDED_ISA_SELECT_RST;
      pc_r       <= VEC_RESET;
      s1_valid_r <= 1'b0;
      s1_addr_r  <= 12'h000;
      s1_write_r <= 1'b0;
      s1_data_r  <= 8'h00;
      s1_null_r  <= 1'b0;
      s1_int_r   <= 1'b0;
      s1_dec_r   <= 1'b0;
      s1_didx_r  <= 2'h0;
      rd_r       <= 8'h00;
      done_r     <= 1'b0;
      aw_have_r  <= 1'b0;
      aw_addr_r  <= 8'h00;
      w_have_r   <= 1'b0;
      w_data_r   <= 32'h0;
      w_strb_r   <= 4'h0;
      bvalid_r   <= 1'b0;
      bresp_r    <= RESP_OKAY;
      rvalid_r   <= 1'b0;
      rresp_r    <= RESP_OKAY;
      rdata_r    <= 32'h0;
    end else begin
      ptr_r      <= ptr_nxt;
      acc_r      <= acc_nxt;
      bank_r     <= bank_nxt;
      extended_isa_select_r    <= extended_isa_select_nxt;
      pc_r       <= pc_nxt;
      s1_valid_r <= s1_valid_nxt;
      s1_addr_r  <= s1_addr_nxt;
      s1_write_r <= s1_write_nxt;
      s1_data_r  <= s1_data_nxt;
      s1_null_r  <= s1_null_nxt;
      s1_int_r   <= s1_int_nxt;
      s1_dec_r   <= s1_dec_nxt;
      s1_didx_r  <= s1_didx_nxt;
      rd_r       <= rd_nxt;
      done_r     <= done_nxt;
      aw_have_r  <= aw_have_nxt;
      aw_addr_r  <= aw_addr_nxt;
      w_have_r   <= w_have_nxt;
      w_data_r   <= w_data_nxt;
      w_strb_r   <= w_strb_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      rvalid_r   <= rvalid_nxt;
      rresp_r    <= rresp_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // checks on the high vector, fetch, operand timing, resolved addresses and their effects
  property p_vec_hi;
    @(posedge clock) disable iff (!rst_b) pc_cmd == PC_VEC_HI |=> pc_r == VEC_HIGH;
  endproperty
  a_vec_hi: assert property (p_vec_hi) else $error("high vector not loaded");
  property p_fetch_zero;
    @(posedge clock) disable iff (!rst_b) ({1'b0, pc_r} >= PM_TOP) |-> fetch_word == FETCH_NOP;
  endproperty
  a_fetch_zero: assert property (p_fetch_zero) else $error("fetch above memory not zero");
  property p_null_read;
    @(posedge clock) disable iff (!rst_b)
      take && w_eff.hit && w_tgt.hit && !op_write |=> ##1 op_done && op_rdata == NULL_READ;
  endproperty
  a_null_read: assert property (p_null_read) else $error("window-on-window read not zero");
  property p_null_write;
    @(posedge clock) disable iff (!rst_b)
      take && w_eff.hit && w_tgt.hit |=> !mem_we && !mem_re ##1 $stable(acc_r);
  endproperty
  a_null_write: assert property (p_null_write) else $error("window-on-window access acted");
  property p_ptr_wr;
    @(posedge clock) disable iff (!rst_b)
      take && op_write && w_eff.hit && tgt_addr == PTR_LO_ADDR[w_eff.idx]
      |=> ##1 ptr_r[$past(w_eff.idx, 2)][7:0] == $past(op_wdata, 2);
  endproperty
  a_ptr_wr: assert property (p_ptr_wr) else $error("pointer write altered");
  property p_indexed;
    @(posedge clock) disable iff (!rst_b)
      take && idx_mode && !w_eff.hit |=> s1_addr_r == $past(idx_sum);
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed target wrong");
  property p_direct;
    @(posedge clock) disable iff (!rst_b)
      take && !idx_mode && !w_eff.hit |=> s1_addr_r == $past(dir_addr);
  endproperty
  a_direct: assert property (p_direct) else $error("direct target wrong");
  property p_plusacc;
    @(posedge clock) disable iff (!rst_b)
      take && w_eff.hit && w_eff.kind == WIN_PLUSACC |=> s1_addr_r == $past(plus_sum);
  endproperty
  a_plusacc: assert property (p_plusacc) else $error("plus-accumulator target wrong");
  property p_op_timing;
    @(posedge clock) disable iff (!rst_b) take |=> !op_ready ##1 op_done && op_ready;
  endproperty
  a_op_timing: assert property (p_op_timing) else $error("operand timing broken");

endmodule

// ==== dag_pkg.sv ====
// constants and types shared by the data address generator files
package dag_pkg;

  // program side
  localparam int          PC_W          = 21;
  localparam int          PM_BYTES_DEF  = 16384;
  localparam logic [20:0] PC_STEP       = 21'h000002;
  localparam logic [20:0] VEC_RESET     = 21'h000000;
  localparam logic [20:0] VEC_HIGH      = 21'h000008;
  localparam logic [20:0] VEC_LOW       = 21'h000018;
  localparam logic [15:0] FETCH_NOP     = 16'h0000;

  // data side
  localparam int          DA_W          = 12;
  localparam logic [7:0]  FA_INDEX_MAX  = 8'h5f;
  localparam logic [7:0]  FA_ACC_SPLIT  = 8'h80;
  localparam logic [3:0]  ACC_HI_BANK   = 4'hf;
  localparam logic [3:0]  ACC_LO_BANK   = 4'h0;
  localparam logic [7:0]  NULL_READ     = 8'h00;

  // special-function addresses of the pointer windows and registers, one entry per pointer for the windows and pointer halves
  localparam logic [11:0] WIN_PLAIN_ADDR [3] = '{12'hfef, 12'hfe7, 12'hfdf};
  localparam logic [11:0] WIN_PDEC_ADDR  [3] = '{12'hfed, 12'hfe5, 12'hfdd};
  localparam logic [11:0] WIN_PACC_ADDR  [3] = '{12'hfeb, 12'hfe3, 12'hfdb};
  localparam logic [11:0] PTR_LO_ADDR    [3] = '{12'hfe9, 12'hfe1, 12'hfd9};
  localparam logic [11:0] PTR_HI_ADDR    [3] = '{12'hfea, 12'hfe2, 12'hfda};
  localparam logic [11:0] ACC_ADDR           = 12'hfe8;
  localparam logic [11:0] BANK_ADDR          = 12'hfe0;
  localparam logic [1:0]  THIRD_PTR          = 2'h2;

  // software register map, byte addresses
  localparam int          AXI_AW        = 8;
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_PTR0      = 8'h04;
  localparam logic [7:0]  REG_PTR1      = 8'h08;
  localparam logic [7:0]  REG_PTR2      = 8'h0c;
  localparam logic [7:0]  REG_ACC       = 8'h10;
  localparam logic [7:0]  REG_BANK      = 8'h14;
  localparam logic [7:0]  REG_PC        = 8'h18;
  localparam int          CTRL_EXTENDED_ISA_SELECT    = 0;
  localparam logic        EXTENDED_ISA_SELECT_RST     = 1'b0;
  localparam logic [11:0] PTR_RST       = 12'h000;
  localparam logic [7:0]  ACC_RST       = 8'h00;
  localparam logic [3:0]  BANK_RST      = 4'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  typedef enum logic [1:0] {
    WIN_NONE    = 2'b00,
    WIN_PLAIN   = 2'b01,
    WIN_POSTDEC = 2'b10,
    WIN_PLUSACC = 2'b11
  } dag_win_t;

  typedef enum logic [2:0] {
    PC_HOLD   = 3'b000,
    PC_INC    = 3'b001,
    PC_LOAD   = 3'b010,
    PC_VEC_HI = 3'b011,
    PC_VEC_LO = 3'b100
  } dag_pc_cmd_t;

endpackage

// ==== dag_win_if.sv ====
// lookup carrier between the core and its window decoder
`timescale 1ns/1ps
interface dag_win_if;
  import dag_pkg::*;
  logic [11:0] addr;
  logic        hit;
  logic [1:0]  idx;
  dag_win_t    kind;
  logic        ptr_reg;
  modport dec (input addr, output hit, output idx, output kind, output ptr_reg);
  modport req (output addr, input hit, input idx, input kind, input ptr_reg);
endinterface

// ==== dag_win_decode.sv ====
// classifies a data address as a pointer window or a pointer register
`timescale 1ns/1ps
module dag_win_decode (
  dag_win_if.dec w
);
  import dag_pkg::*;

  // five compares per pointer; a miss leaves everything cleared
  always_comb begin
    w.hit     = 1'b0;
    w.idx     = 2'h0;
    w.kind    = WIN_NONE;
    w.ptr_reg = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (w.addr == WIN_PLAIN_ADDR[i]) begin
        w.hit  = 1'b1;
        w.idx  = 2'(i);
        w.kind = WIN_PLAIN;
      end
      if (w.addr == WIN_PDEC_ADDR[i]) begin
        w.hit  = 1'b1;
        w.idx  = 2'(i);
        w.kind = WIN_POSTDEC;
      end
      if (w.addr == WIN_PACC_ADDR[i]) begin
        w.hit  = 1'b1;
        w.idx  = 2'(i);
        w.kind = WIN_PLUSACC;
      end
      if ((w.addr == PTR_LO_ADDR[i]) || (w.addr == PTR_HI_ADDR[i])) begin
        w.ptr_reg = 1'b1;
      end
    end
  end

endmodule

// ==== dag_mem_model.sv ====
// data and program memory model facing the address generator
`timescale 1ns/1ps
module dag_mem_model (
  input  wire logic [0:0]  clock,
  input  wire logic [11:0] mem_addr,
  input  wire logic        mem_re,
  input  wire logic        mem_we,
  input  wire logic [7:0]  mem_wdata,
  output logic [7:0]       mem_rdata,
  input  wire logic [20:0] pm_addr,
  output logic [15:0]      pm_rdata
);
  logic [7:0] ram [4096];
  logic [7:0] last_r;
  // each byte seeded from its address, so a wrong address shows as a wrong value
  initial begin
    for (int i = 0; i < 4096; i++) ram[i] = i[7:0] ^ {4'h0, i[11:8]};
    last_r = 8'h00;
  end
  // unselected bus shows the inverse of the last byte, never a stale copy
  assign mem_rdata = mem_re ? ram[mem_addr] : ~last_r;
  // writes land at the edge that ends the strobe cycle
  always @(posedge clock) begin
    if (mem_we) ram[mem_addr] <= mem_wdata;
    if (mem_re) last_r <= ram[mem_addr];
  end
  // program bus is separate and answers every cycle, data traffic or not
  assign pm_rdata = {1'h1, pm_addr[15:1]};
endmodule

// ==== tb_top.sv ====
// testbench: register bus, program counter and operand port sequences
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("FAIL %s exp %h got %h", nm, e, s); end end
module tb_top;
  import dag_pkg::*;
  logic        clock, rst_b;
  logic [7:0]  awaddr, araddr, op_faddr, op_wdata, op_rdata, mem_wdata, mem_rdata;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic        rvalid, rready, op_valid, op_ready, op_access, op_write, op_done;
  logic        mem_re, mem_we;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [11:0] mem_addr;
  dag_pc_cmd_t pc_cmd;
  logic [20:0] pc_load_addr, pm_addr;
  logic [15:0] pm_rdata, fetch_word;
  int          error_cnt, n_checks;

  dag_core #(.PM_BYTES(PM_BYTES_DEF)) DUT (.clock, .rst_b, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .op_valid, .op_ready, .op_faddr,
    .op_access, .op_write, .op_wdata, .op_rdata, .op_done, .mem_addr, .mem_re, .mem_we,
    .mem_wdata, .mem_rdata, .pc_cmd, .pc_load_addr, .pm_addr, .pm_rdata, .fetch_word);
  dag_mem_model MEM (.clock, .mem_addr, .mem_re, .mem_we, .mem_wdata, .mem_rdata,
    .pm_addr, .pm_rdata);

  // 25 MHz core clock
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // a wait that used its whole bound counts as a mismatch and ends the run
  task automatic lim(input int k);
    if (k >= 20) begin
      error_cnt++;
      end_sim();
    end
  endtask

  function automatic logic [7:0] mv(input logic [11:0] a);
    return a[7:0] ^ {4'h0, a[11:8]};
  endfunction

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (k = 0; k < 20; k++) begin
      @(posedge clock);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
    end
    bready <= 1'h0;
    lim(k);
    `CHK("bresp", er, bresp)
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (k = 0; k < 20; k++) begin
      @(posedge clock);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    rready <= 1'h0;
    lim(k);
    `CHK("rdata", ed, rdata)
    `CHK("rresp", er, rresp)
  endtask

  // one operand access; st says whether a memory strobe is expected at ea
  task automatic op(input logic [7:0] fa, input logic ac, wr, input logic [7:0] wd,
                    input logic [11:0] ea, input logic st, input logic [7:0] ed);
    int k;
    @(posedge clock);
    op_faddr <= fa;
    op_access <= ac;
    op_write <= wr;
    op_wdata <= wd;
    op_valid <= 1'h1;
    for (k = 0; k < 20; k++) begin
      @(posedge clock);
      if (op_ready === 1'h1) break;
    end
    lim(k);
    op_valid <= 1'h0;
    @(negedge clock);
    `CHK("mem_re", st & ~wr, mem_re)
    `CHK("mem_we", st & wr, mem_we)
    if (st) `CHK("mem_addr", ea, mem_addr)
    if (st && wr) `CHK("mem_wdata", wd, mem_wdata)
    @(negedge clock);
    `CHK("op_done", 1'h1, op_done)
    if (!wr) `CHK("op_rdata", st ? mv(ea) : ed, op_rdata)
  endtask

  // command sampled at one edge, counter seen the cycle after
  task automatic pc(input dag_pc_cmd_t c, input logic [20:0] ld, ea);
    @(posedge clock);
    pc_cmd <= c;
    pc_load_addr <= ld;
    @(posedge clock);
    pc_cmd <= PC_HOLD;
    @(negedge clock);
    `CHK("pm_addr", ea, pm_addr)
    `CHK("fetch_word", (ea < PM_BYTES_DEF) ? {1'h1, ea[15:1]} : 16'h0000, fetch_word)
  endtask

  initial begin
    rst_b = 1'h0;
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    {op_valid, op_faddr, op_access, op_write, op_wdata, pc_load_addr} = '0;
    wstrb = 4'hf;
    pc_cmd = PC_HOLD;
    error_cnt = 0;
    n_checks = 0;
    repeat (10) @(posedge clock);
    rst_b <= 1'h1;
    axr(REG_CTRL, 32'h0, RESP_OKAY);
    axr(REG_PC, 32'h0, RESP_OKAY);
    axr(8'h1c, 32'h0, RESP_SLVERR);
    axw(REG_PC, 32'h4, RESP_SLVERR);
    pc(PC_VEC_HI, 21'h0, 21'h000008);
    pc(PC_VEC_LO, 21'h0, 21'h000018);
    pc(PC_LOAD, 21'h003ffe, 21'h003ffe);
    pc(PC_INC, 21'h0, 21'h004000);
    pc(PC_LOAD, 21'h1ffffe, 21'h1ffffe);
    axr(REG_PC, 32'h1ffffe, RESP_OKAY);
    pc(PC_INC, 21'h0, 21'h000000);
    // low access addresses stay direct until extended mode is on
    axw(REG_BANK, 32'h3, RESP_OKAY);
    axw(REG_PTR2, 32'hfb0, RESP_OKAY);
    op(8'h20, 1'h0, 1'h0, 8'h0, 12'h020, 1'h1, 8'h0);
    axw(REG_CTRL, 32'h1, RESP_OKAY);
    op(8'h20, 1'h0, 1'h0, 8'h0, 12'hfd0, 1'h1, 8'h0);
    op(8'h5f, 1'h0, 1'h0, 8'h0, 12'h00f, 1'h1, 8'h0);
    op(8'h60, 1'h0, 1'h0, 8'h0, 12'h060, 1'h1, 8'h0);
    op(8'h90, 1'h0, 1'h0, 8'h0, 12'hf90, 1'h1, 8'h0);
    op(8'h45, 1'h1, 1'h0, 8'h0, 12'h345, 1'h1, 8'h0);
    pc(PC_INC, 21'h0, 21'h000002);
    // pointer windows with extended mode still on
    axw(REG_PTR0, 32'h123, RESP_OKAY);
    op(8'hef, 1'h0, 1'h0, 8'h0, 12'h123, 1'h1, 8'h0);
    axw(REG_PTR1, 32'h200, RESP_OKAY);
    axw(REG_ACC, 32'hfe, RESP_OKAY);
    op(8'he3, 1'h0, 1'h0, 8'h0, 12'h1fe, 1'h1, 8'h0);
    // pointer aimed at window one: read gives zero, write is dropped
    axw(REG_PTR0, 32'hfe7, RESP_OKAY);
    op(8'hef, 1'h0, 1'h0, 8'h0, 12'h0, 1'h0, 8'h00);
    op(8'hef, 1'h0, 1'h1, 8'h99, 12'h0, 1'h0, 8'h0);
    axr(REG_PTR1, 32'h200, RESP_OKAY);
    // the byte behind window one must still hold its seed after the dropped write
    op(8'he7, 1'h0, 1'h0, 8'h0, 12'h200, 1'h1, 8'h0);
    axw(REG_PTR2, 32'h300, RESP_OKAY);
    op(8'hdd, 1'h0, 1'h0, 8'h0, 12'h300, 1'h1, 8'h0);
    axr(REG_PTR2, 32'h2ff, RESP_OKAY);
    // writing a pointer through its own decrement window must not decrement
    axw(REG_PTR2, 32'hfd9, RESP_OKAY);
    op(8'hdd, 1'h0, 1'h1, 8'h77, 12'h0, 1'h0, 8'h0);
    axr(REG_PTR2, 32'hf77, RESP_OKAY);
    op(8'he9, 1'h0, 1'h1, 8'h34, 12'h0, 1'h0, 8'h0);
    axr(REG_PTR0, 32'hf34, RESP_OKAY);
    op(8'he9, 1'h0, 1'h0, 8'h0, 12'h0, 1'h0, 8'h34);
    axw(REG_PTR1, 32'hfe8, RESP_OKAY);
    op(8'he7, 1'h0, 1'h1, 8'h55, 12'h0, 1'h0, 8'h0);
    axr(REG_ACC, 32'h55, RESP_OKAY);
    // indexed store goes to memory at third pointer plus offset
    op(8'h10, 1'h0, 1'h1, 8'h5a, 12'hf87, 1'h1, 8'h0);
    end_sim();
  end
endmodule
